//--- rtl/ccd_timing_pkg.sv
package ccd_timing_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register map
  localparam int NUM_ADDR = 27;
  localparam logic [4:0] ADDR_BANK_SELECT = 5'h00;
  localparam logic [4:0] ADDR_FIRST_BANK_START = 5'h01;
  localparam logic [4:0] ADDR_SECOND_BANK_START = 5'h0E;
  localparam logic [4:0] ADDR_LAST = 5'h1A;
  localparam logic [4:0] ADDR_SEQ1_TOGGLE1_LOW_BYTE = 5'h07;
  localparam logic [4:0] ADDR_SEQ1_TOGGLE2_HIGH_NIBBLE = 5'h08;
  localparam logic [4:0] ADDR_SEQ1_TOGGLE2_LOW_BYTE = 5'h09;
  localparam logic [4:0] ADDR_SEQ2_TOGGLE1_HIGH_NIBBLE = 5'h0A;
  localparam logic [4:0] ADDR_SEQ2_TOGGLE1_LOW_BYTE = 5'h0B;
  localparam logic [4:0] ADDR_SEQ2_TOGGLE2_HIGH_NIBBLE = 5'h0C;
  localparam logic [4:0] ADDR_SEQ2_TOGGLE2_LOW_BYTE = 5'h0D;
  localparam logic [4:0] ADDR_GATE_AND_LAST_CLOCK_DRIVE_POLARITY = 5'h0E;
  localparam logic [4:0] ADDR_LAST_CLOCK_RISE_LOCATION = 5'h0F;
  localparam logic [4:0] ADDR_LAST_CLOCK_FALL_LOCATION = 5'h10;
  localparam logic [4:0] ADDR_GATE_RISE_LOCATION = 5'h11;
  localparam logic [4:0] ADDR_GATE_FALL_LOCATION = 5'h12;
  localparam logic [4:0] ADDR_HORIZONTAL_DRIVE_STRENGTH = 5'h13;
  localparam logic [4:0] ADDR_HORIZONTAL_RISE_LOCATION_POLARITY = 5'h14;
  localparam logic [4:0] ADDR_HORIZONTAL_FALL_LOCATION = 5'h15;
  localparam logic [4:0] ADDR_REFERENCE_SAMPLE_LOCATION = 5'h16;
  localparam logic [4:0] ADDR_DATA_SAMPLE_LOCATION = 5'h17;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int BANK_SELECT_BIT = 7;
  localparam int GATE_DRIVE_LSB = 0;
  localparam int GATE_POLARITY_BIT = 3;
  localparam int LAST_CLOCK_DRIVE_LSB = 4;
  localparam int LAST_CLOCK_POLARITY_BIT = 7;
  localparam int EVEN_HORIZONTAL_DRIVE_LSB = 0;
  localparam int ODD_HORIZONTAL_DRIVE_LSB = 4;
  localparam int HORIZONTAL_POLARITY_BIT = 7;
  localparam int LOCATION_LSB = 0;
  localparam int NIBBLE_LSB = 0;

  ////////////////////////////////////////////////////////////////////////////
  // Values after reset, and bits that hold storage (others stay zero)
  localparam logic [7:0] RESET_VALUE [0:NUM_ADDR-1] = '{
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h40, 8'h00, 8'h40, 8'h00, 8'h40, 8'h00, 8'h40,
    8'h33, 8'h00, 8'h18, 8'h00, 8'h18, 8'h77, 8'h00,
    8'h20, 8'h20, 8'h00, 8'h00, 8'h00, 8'h00};
  localparam logic [7:0] WRITE_MASK [0:NUM_ADDR-1] = '{
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'hFF, 8'h0F, 8'hFF, 8'h0F, 8'hFF, 8'h0F, 8'hFF,
    8'hFF, 8'h3F, 8'h3F, 8'h3F, 8'h3F, 8'hFF, 8'hBF,
    8'h3F, 8'h3F, 8'h3F, 8'h00, 8'h00, 8'h00};

  ////////////////////////////////////////////////////////////////////////////
  // Timing core
  localparam int STEPS_PER_PIXEL = 48;
  localparam int QUADRANT_SIZE = 12;
  localparam logic [5:0] LAST_STEP = 6'(STEPS_PER_PIXEL - 1);
  localparam int BITS_PER_WORD = 8;
  localparam logic [2:0] LAST_BIT = 3'(BITS_PER_WORD - 1);

  typedef enum logic {LINK_IDLE, LINK_SHIFT} link_state_t;

  typedef struct packed {
    logic gate_clock;
    logic last_clock;
    logic odd_horizontal_clocks;
    logic even_horizontal_clocks;
    logic reference_sample_clock;
    logic data_sample_clock;
  } timing_clocks_t;

  typedef struct packed {
    logic [2:0] gate_drive_strength;
    logic [2:0] last_clock_drive_strength;
    logic [3:0] odd_horizontal_drive;
    logic [3:0] even_horizontal_drive;
  } drive_settings_t;

  // Quadrant code to step: upper two bits pick a quadrant of twelve steps
  function automatic logic [5:0] code_to_step(input logic [5:0] code);
    code_to_step = 6'(6'(code[5:4]) * 6'(QUADRANT_SIZE) + 6'(code[3:0]));
  endfunction : code_to_step

endpackage : ccd_timing_pkg

//--- rtl/level_sync.sv
`timescale 1ns/1ps
module level_sync #(
  // Reset to the pin's idle level so no false edge follows reset
  parameter logic IDLE_LEVEL = 1'b0
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic async_in,
  output logic sync_out
);
  logic first_stage;
  logic next_first_stage;
  logic next_sync_out;

  always_comb begin
    next_first_stage = async_in;
    next_sync_out = first_stage;
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      first_stage <= IDLE_LEVEL;
      sync_out <= IDLE_LEVEL;
    end else begin
      first_stage <= next_first_stage;
      sync_out <= next_sync_out;
    end
  end
endmodule : level_sync

//--- rtl/edge_pulse_gen.sv
`timescale 1ns/1ps
module edge_pulse_gen (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [5:0] step,
  input wire logic [5:0] rise_code,
  input wire logic [5:0] fall_code,
  input wire logic invert,
  output logic level,
  output logic level_n
);
  logic raw;
  logic next_raw;
  logic next_level;
  logic next_level_n;

  always_comb begin
    next_raw = raw;
    // Rise wins when both edges land on one step
    if (step == ccd_timing_pkg::code_to_step(rise_code)) begin
      next_raw = 1'b1;
    end else if (step == ccd_timing_pkg::code_to_step(fall_code)) begin
      next_raw = 1'b0;
    end
    next_level = next_raw ^ invert;
    // Complement taken from the same term so the pair never overlaps
    next_level_n = ~next_level;
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      raw <= 1'b0;
      level <= 1'b0;
      level_n <= 1'b1;
    end else begin
      raw <= next_raw;
      level <= next_level;
      level_n <= next_level_n;
    end
  end
endmodule : edge_pulse_gen

//--- rtl/ccd_timing_register_bank.sv
`timescale 1ns/1ps
// Summary of operation
// [R1] Address 7 holds sequence 1 first toggle low byte, reset 0x40.
// [R2] Sequence 1 second toggle: nibble at 8, byte at 9, reset bit 6.
// [R3] Sequence 2 first toggle: nibble at 10, byte at 11, reset bit 6.
// [R4] Sequence 2 second toggle: nibble at 12, byte at 13, reset bit 6.
// [R5] Address 14 bits 2:0 gate drive, reset 3; bit 3 inverts gate.
// [R6] Address 14 bits 6:4 last clock drive, reset 3; bit 7 inverts.
// [R7] Last clock rise at 15 reset 0, fall at 16 reset 24.
// [R8] Gate rise at 17 reset 0, fall at 18 reset 24.
// [R9] Address 19 bits 3:0 even horizontal drive, reset 7, zero off.
// [R10] Address 19 bits 7:4 odd horizontal drive, reset 7, zero off.
// [R11] Address 20 bits 5:0 horizontal rise, reset 0; bit 6 unused.
// [R12] Address 20 bit 7 odd polarity; even outputs always opposite.
// [R13] Address 21 holds horizontal fall location, reset 32.
// [R14] Reference sample at 22 reset 32; data sample at 23 reset 0.
// [R15] Locations are quadrant codes of twelve; host writes valid codes only.
// [R16] Each pixel period is split into 48 equal steps.
// [R17] A burst's bytes all take effect on the load strobe's rising edge.
// [R18] Host writes zero to test fields; device ignores unused bits.
// [R19] Every byte resets to its default; unused bits read zero.
module ccd_timing_register_bank (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic serial_clock,
  input wire logic serial_data,
  input wire logic serial_load_strobe,
  output ccd_timing_pkg::timing_clocks_t clocks,
  output ccd_timing_pkg::drive_settings_t drives,
  output logic gate_polarity,
  output logic last_clock_polarity,
  output logic horizontal_polarity,
  output logic [7:0] seq1_blank_toggle_first_position_low,
  output logic [11:0] seq1_blank_toggle_second_position,
  output logic [11:0] seq2_blank_toggle_first_position,
  output logic [11:0] seq2_blank_toggle_second_position,
  output logic [5:0] pixel_step,
  output logic bank_select
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic sck_sync;
  logic sdi_sync;
  logic sl_sync;

  level_sync sck_sync_inst (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .async_in(serial_clock),
    .sync_out(sck_sync)
  );

  level_sync sdi_sync_inst (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .async_in(serial_data),
    .sync_out(sdi_sync)
  );

  // Strobe idles high; a low reset value would fake a burst start
  level_sync #(
    .IDLE_LEVEL(1'b1)
  ) sl_sync_inst (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .async_in(serial_load_strobe),
    .sync_out(sl_sync)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Serial word capture into a staging copy
  ccd_timing_pkg::link_state_t state;
  ccd_timing_pkg::link_state_t next_state;
  logic sck_prev;
  logic next_sck_prev;
  logic sl_prev;
  logic next_sl_prev;
  logic [7:0] shift;
  logic [7:0] next_shift;
  logic [2:0] bit_count;
  logic [2:0] next_bit_count;
  logic [4:0] word_addr;
  logic [4:0] next_word_addr;
  logic burst_bank;
  logic next_burst_bank;
  logic [7:0] staged [0:ccd_timing_pkg::NUM_ADDR-1];
  logic [7:0] next_staged [0:ccd_timing_pkg::NUM_ADDR-1];
  logic [ccd_timing_pkg::NUM_ADDR-1:0] pending;
  logic [ccd_timing_pkg::NUM_ADDR-1:0] next_pending;
  logic commit;
  logic [7:0] word_in;

  always_comb begin
    next_state = state;
    next_sck_prev = sck_sync;
    next_sl_prev = sl_sync;
    next_shift = shift;
    next_bit_count = bit_count;
    next_word_addr = word_addr;
    next_burst_bank = burst_bank;
    next_staged = staged;
    next_pending = pending;
    word_in = {sdi_sync, shift[7:1]};
    commit = 1'b0;
    case (state)
      ccd_timing_pkg::LINK_IDLE: begin
        next_bit_count = 3'h0;
        next_word_addr = ccd_timing_pkg::ADDR_BANK_SELECT;
        if (!sl_sync) begin
          next_state = ccd_timing_pkg::LINK_SHIFT;
        end
      end
      ccd_timing_pkg::LINK_SHIFT: begin
        if (sl_sync && !sl_prev) begin
          // Whole burst lands at once; half-shifted word is dropped
          commit = 1'b1; // R17
          next_pending = '0;
          next_state = ccd_timing_pkg::LINK_IDLE;
        end else if (sck_sync && !sck_prev) begin
          // Least significant bit arrives first
          next_shift = word_in;
          next_bit_count = bit_count + 3'h1;
          if (bit_count == ccd_timing_pkg::LAST_BIT) begin
            if (word_addr <= ccd_timing_pkg::ADDR_LAST) begin
              next_staged[word_addr] = word_in & ccd_timing_pkg::WRITE_MASK[word_addr]; // R18
              next_pending[word_addr] = 1'b1;
            end
            if (word_addr == ccd_timing_pkg::ADDR_BANK_SELECT) begin
              next_burst_bank = word_in[ccd_timing_pkg::BANK_SELECT_BIT];
              next_word_addr = word_in[ccd_timing_pkg::BANK_SELECT_BIT] ?
                               ccd_timing_pkg::ADDR_SECOND_BANK_START :
                               ccd_timing_pkg::ADDR_FIRST_BANK_START;
            end else if (word_addr <= ccd_timing_pkg::ADDR_LAST) begin
              // Past the last address further words are ignored
              next_word_addr = word_addr + 5'h01;
            end
          end
        end
      end
      default: begin
        next_state = ccd_timing_pkg::LINK_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state <= ccd_timing_pkg::LINK_IDLE;
      sck_prev <= 1'b0;
      sl_prev <= 1'b1;
      shift <= 8'h00;
      bit_count <= 3'h0;
      word_addr <= 5'h00;
      burst_bank <= 1'b0;
      pending <= '0;
      for (int i = 0; i < ccd_timing_pkg::NUM_ADDR; i++) begin
        staged[i] <= 8'h00;
      end
    end else begin
      state <= next_state;
      sck_prev <= next_sck_prev;
      sl_prev <= next_sl_prev;
      shift <= next_shift;
      bit_count <= next_bit_count;
      word_addr <= next_word_addr;
      burst_bank <= next_burst_bank;
      pending <= next_pending;
      staged <= next_staged;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Live register file, updated only by a commit
  logic [7:0] regs [0:ccd_timing_pkg::NUM_ADDR-1];
  logic [7:0] next_regs [0:ccd_timing_pkg::NUM_ADDR-1];
  logic next_bank_select;

  always_comb begin
    next_regs = regs;
    next_bank_select = bank_select;
    if (commit) begin
      for (int i = 0; i < ccd_timing_pkg::NUM_ADDR; i++) begin
        if (pending[i]) begin
          next_regs[i] = staged[i]; // R17
        end
      end
      if (pending[ccd_timing_pkg::ADDR_BANK_SELECT]) begin
        next_bank_select = burst_bank;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < ccd_timing_pkg::NUM_ADDR; i++) begin
        regs[i] <= ccd_timing_pkg::RESET_VALUE[i]; // R19 R1 R2 R3 R4
      end
      bank_select <= 1'b0;
    end else begin
      regs <= next_regs;
      bank_select <= next_bank_select;
    end
  end

  // Register fields are flip-flops, so these outputs come straight from them
  assign seq1_blank_toggle_first_position_low =
    regs[ccd_timing_pkg::ADDR_SEQ1_TOGGLE1_LOW_BYTE]; // R1
  assign seq1_blank_toggle_second_position = {
    regs[ccd_timing_pkg::ADDR_SEQ1_TOGGLE2_HIGH_NIBBLE][ccd_timing_pkg::NIBBLE_LSB +: 4],
    regs[ccd_timing_pkg::ADDR_SEQ1_TOGGLE2_LOW_BYTE]}; // R2
  assign seq2_blank_toggle_first_position = {
    regs[ccd_timing_pkg::ADDR_SEQ2_TOGGLE1_HIGH_NIBBLE][ccd_timing_pkg::NIBBLE_LSB +: 4],
    regs[ccd_timing_pkg::ADDR_SEQ2_TOGGLE1_LOW_BYTE]}; // R3
  assign seq2_blank_toggle_second_position = {
    regs[ccd_timing_pkg::ADDR_SEQ2_TOGGLE2_HIGH_NIBBLE][ccd_timing_pkg::NIBBLE_LSB +: 4],
    regs[ccd_timing_pkg::ADDR_SEQ2_TOGGLE2_LOW_BYTE]}; // R4
  assign drives.gate_drive_strength =
    regs[ccd_timing_pkg::ADDR_GATE_AND_LAST_CLOCK_DRIVE_POLARITY]
        [ccd_timing_pkg::GATE_DRIVE_LSB +: 3]; // R5
  assign drives.last_clock_drive_strength =
    regs[ccd_timing_pkg::ADDR_GATE_AND_LAST_CLOCK_DRIVE_POLARITY]
        [ccd_timing_pkg::LAST_CLOCK_DRIVE_LSB +: 3]; // R6
  assign drives.even_horizontal_drive =
    regs[ccd_timing_pkg::ADDR_HORIZONTAL_DRIVE_STRENGTH]
        [ccd_timing_pkg::EVEN_HORIZONTAL_DRIVE_LSB +: 4]; // R9
  assign drives.odd_horizontal_drive =
    regs[ccd_timing_pkg::ADDR_HORIZONTAL_DRIVE_STRENGTH]
        [ccd_timing_pkg::ODD_HORIZONTAL_DRIVE_LSB +: 4]; // R10
  assign gate_polarity = regs[ccd_timing_pkg::ADDR_GATE_AND_LAST_CLOCK_DRIVE_POLARITY]
                             [ccd_timing_pkg::GATE_POLARITY_BIT]; // R5
  assign last_clock_polarity = regs[ccd_timing_pkg::ADDR_GATE_AND_LAST_CLOCK_DRIVE_POLARITY]
                                   [ccd_timing_pkg::LAST_CLOCK_POLARITY_BIT]; // R6
  assign horizontal_polarity = regs[ccd_timing_pkg::ADDR_HORIZONTAL_RISE_LOCATION_POLARITY]
                                   [ccd_timing_pkg::HORIZONTAL_POLARITY_BIT]; // R12

  ////////////////////////////////////////////////////////////////////////////
  // Pixel step counter and sample strobes
  logic [5:0] next_pixel_step;
  logic next_reference_sample;
  logic next_data_sample;
  logic reference_sample;
  logic data_sample;
  logic [5:0] reference_code;
  logic [5:0] data_code;

  assign reference_code = regs[ccd_timing_pkg::ADDR_REFERENCE_SAMPLE_LOCATION]
                              [ccd_timing_pkg::LOCATION_LSB +: 6];
  assign data_code = regs[ccd_timing_pkg::ADDR_DATA_SAMPLE_LOCATION]
                         [ccd_timing_pkg::LOCATION_LSB +: 6];

  always_comb begin
    // One pixel period spans 48 reference clocks in this model
    if (pixel_step == ccd_timing_pkg::LAST_STEP) begin
      next_pixel_step = 6'h00; // R16
    end else begin
      next_pixel_step = pixel_step + 6'h01;
    end
    // Invalid codes (low nibble above 11) alias onto the next quadrant; in the last quadrant they never match
    next_reference_sample =
      (pixel_step == ccd_timing_pkg::code_to_step(reference_code)); // R14 R15
    next_data_sample = (pixel_step == ccd_timing_pkg::code_to_step(data_code)); // R14 R15
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pixel_step <= 6'h00;
      reference_sample <= 1'b0;
      data_sample <= 1'b0;
    end else begin
      pixel_step <= next_pixel_step;
      reference_sample <= next_reference_sample;
      data_sample <= next_data_sample;
    end
  end

  assign clocks.reference_sample_clock = reference_sample;
  assign clocks.data_sample_clock = data_sample;

  ////////////////////////////////////////////////////////////////////////////
  // Edge generators
  logic gate_level;
  logic last_level;
  logic odd_level;
  logic even_level;

  edge_pulse_gen gate_gen (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .step(pixel_step),
    .rise_code(regs[ccd_timing_pkg::ADDR_GATE_RISE_LOCATION][5:0]), // R8
    .fall_code(regs[ccd_timing_pkg::ADDR_GATE_FALL_LOCATION][5:0]),
    .invert(gate_polarity),
    .level(gate_level),
    .level_n()
  );

  edge_pulse_gen last_gen (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .step(pixel_step),
    .rise_code(regs[ccd_timing_pkg::ADDR_LAST_CLOCK_RISE_LOCATION][5:0]), // R7
    .fall_code(regs[ccd_timing_pkg::ADDR_LAST_CLOCK_FALL_LOCATION][5:0]),
    .invert(last_clock_polarity),
    .level(last_level),
    .level_n()
  );

  edge_pulse_gen horizontal_gen (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .step(pixel_step),
    .rise_code(regs[ccd_timing_pkg::ADDR_HORIZONTAL_RISE_LOCATION_POLARITY][5:0]), // R11
    .fall_code(regs[ccd_timing_pkg::ADDR_HORIZONTAL_FALL_LOCATION][5:0]), // R13
    .invert(horizontal_polarity),
    .level(odd_level),
    .level_n(even_level) // R12
  );

  assign clocks.gate_clock = gate_level;
  assign clocks.last_clock = last_level;
  assign clocks.odd_horizontal_clocks = odd_level;
  assign clocks.even_horizontal_clocks = even_level;

endmodule : ccd_timing_register_bank

//--- tb/ccd_serial_host.sv
`timescale 1ns/1ps
module ccd_serial_host (
  input wire logic ref_clk,
  output logic serial_clock,
  output logic serial_data,
  output logic serial_load_strobe
);
  // One more than the three cycles the pin sync needs
  localparam int HOLD = 4;
  initial begin
    serial_clock = 1'b0;
    serial_data = 1'b0;
    serial_load_strobe = 1'b1;
  end
  task automatic wait_hold();
    repeat (HOLD) @(posedge ref_clk);
    #1;
  endtask : wait_hold
  task automatic write_burst(input logic bank, input logic [7:0] words[$]);
    logic [7:0] w;
    words.push_front({bank, 7'h00});
    @(posedge ref_clk);
    #1;
    serial_load_strobe = 1'b0;
    wait_hold();
    foreach (words[i]) begin
      w = words[i];
      for (int b = 0; b < 8; b++) begin
        serial_data = w[b];
        serial_clock = 1'b0;
        wait_hold();
        serial_clock = 1'b1;
        wait_hold();
      end
    end
    serial_clock = 1'b0;
    wait_hold();
    serial_load_strobe = 1'b1;
    // Stale data must not look valid
    serial_data = ~serial_data;
    wait_hold();
  endtask : write_burst
endmodule : ccd_serial_host

//--- tb/ccd_timing_register_bank_chk.sv
`timescale 1ns/1ps
module ccd_timing_register_bank_chk (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic serial_load_strobe,
  input wire ccd_timing_pkg::timing_clocks_t clocks,
  input wire ccd_timing_pkg::drive_settings_t drives,
  input wire logic gate_polarity,
  input wire logic last_clock_polarity,
  input wire logic horizontal_polarity,
  input wire logic [11:0] seq1_blank_toggle_second_position,
  input wire logic [11:0] seq2_blank_toggle_first_position,
  input wire logic [5:0] pixel_step,
  input wire logic bank_select
);
  logic strobe_seen;
  logic next_strobe_seen;
  logic [3:0] since_rise;
  logic [3:0] next_since_rise;
  logic [3:0] low_run;
  logic [3:0] next_low_run;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  always_comb begin
    next_strobe_seen = serial_load_strobe;
    next_since_rise = (since_rise == 4'hF) ? since_rise : since_rise + 4'h1;
    if (serial_load_strobe && !strobe_seen) begin
      next_since_rise = 4'h0;
    end
    next_low_run = (low_run == 4'hF) ? low_run : low_run + 4'h1;
    if (serial_load_strobe) begin
      next_low_run = 4'h0;
    end
  end
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      strobe_seen <= 1'b1;
      since_rise <= 4'hF;
      low_run <= 4'h0;
    end else begin
      strobe_seen <= next_strobe_seen;
      since_rise <= next_since_rise;
      low_run <= next_low_run;
    end
  end
  a_even_opposite: assert property (
    clocks.even_horizontal_clocks != clocks.odd_horizontal_clocks)
    else $error("even clocks equal odd clocks");
  a_step_wrap: assert property (pixel_step == 6'h2F |=> pixel_step == 6'h00)
    else $error("step counter did not wrap after 47");
  a_step_advance: assert property (
    pixel_step != 6'h2F |=> pixel_step == $past(pixel_step) + 6'h01)
    else $error("step counter did not advance by one");
  a_step_restart: assert property (
    !$past(resetn) |-> pixel_step == 6'h00 ##1 pixel_step == 6'h01)
    else $error("step counter wrong after reset");
  a_ref_single: assert property (
    clocks.reference_sample_clock |=> !clocks.reference_sample_clock [*4])
    else $error("reference sample pulse too long");
  a_data_single: assert property (
    $rose(clocks.data_sample_clock) |=> $fell(clocks.data_sample_clock))
    else $error("data sample pulse not one cycle");
  a_drive_commit: assert property (!$stable(drives) |-> since_rise inside {[2:6]})
    else $error("drive settings changed outside a commit");
  a_polarity_commit: assert property (
    $changed({gate_polarity, last_clock_polarity, horizontal_polarity, bank_select})
    |-> since_rise >= 4'h2 && since_rise <= 4'h6)
    else $error("polarity or bank changed outside a commit");
  a_burst_hold: assert property (low_run > 4'h8 |=>
    $stable(seq1_blank_toggle_second_position) && $stable(seq2_blank_toggle_first_position))
    else $error("toggle position changed during a burst");
endmodule : ccd_timing_register_bank_chk
bind ccd_timing_register_bank ccd_timing_register_bank_chk chk (
  .ref_clk(ref_clk),
  .resetn(resetn),
  .serial_load_strobe(serial_load_strobe),
  .clocks(clocks),
  .drives(drives),
  .gate_polarity(gate_polarity),
  .last_clock_polarity(last_clock_polarity),
  .horizontal_polarity(horizontal_polarity),
  .seq1_blank_toggle_second_position(seq1_blank_toggle_second_position),
  .seq2_blank_toggle_first_position(seq2_blank_toggle_first_position),
  .pixel_step(pixel_step),
  .bank_select(bank_select)
);

//--- tb/ccd_timing_register_bank_tb.sv
`timescale 1ns/1ps
module ccd_timing_register_bank_tb;
  localparam ccd_timing_pkg::drive_settings_t DRV_RST = {3'h3, 3'h3, 4'h7, 4'h7};
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic serial_clock;
  logic serial_data;
  logic serial_load_strobe;
  ccd_timing_pkg::timing_clocks_t clocks;
  ccd_timing_pkg::drive_settings_t drives;
  logic gate_polarity;
  logic last_clock_polarity;
  logic horizontal_polarity;
  logic [2:0] pols;
  logic [7:0] seq1_low;
  logic [11:0] seq1_second;
  logic [11:0] seq2_first;
  logic [11:0] seq2_second;
  logic [5:0] pixel_step;
  logic bank_select;
  int errors = 0;
  int num_checks = 0;
  int cycles = 0;
  assign pols = {gate_polarity, last_clock_polarity, horizontal_polarity};
  always #5 ref_clk = ~ref_clk;
  ccd_serial_host host (.ref_clk(ref_clk), .serial_clock(serial_clock),
    .serial_data(serial_data), .serial_load_strobe(serial_load_strobe));
  ccd_timing_register_bank uut (.ref_clk(ref_clk), .resetn(resetn),
    .serial_clock(serial_clock), .serial_data(serial_data),
    .serial_load_strobe(serial_load_strobe), .clocks(clocks), .drives(drives),
    .gate_polarity(gate_polarity), .last_clock_polarity(last_clock_polarity),
    .horizontal_polarity(horizontal_polarity),
    .seq1_blank_toggle_first_position_low(seq1_low),
    .seq1_blank_toggle_second_position(seq1_second),
    .seq2_blank_toggle_first_position(seq2_first),
    .seq2_blank_toggle_second_position(seq2_second),
    .pixel_step(pixel_step), .bank_select(bank_select));
  ////////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : finish_test
  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check
  function automatic logic [5:0] step_of(input logic [5:0] c);
    step_of = 6'(c[5:4]) * 6'h0C + 6'(c[3:0]);
  endfunction : step_of
  // Outputs are registered, so the edge shows one step after its location
  task automatic edge_at(input int bit_i, input logic lvl, input logic [5:0] code,
    input string what);
    logic prev;
    int n;
    logic [5:0] exp;
    exp = (step_of(code) == 6'h2F) ? 6'h00 : step_of(code) + 6'h01;
    prev = clocks[bit_i];
    n = 0;
    while (!(clocks[bit_i] === lvl && prev !== lvl) && n < 100) begin
      prev = clocks[bit_i];
      @(posedge ref_clk);
      #2;
      n++;
    end
    // An edge never seen counts as a mismatch
    check(16'({n < 100, pixel_step}), 16'({1'b1, exp}), what);
  endtask : edge_at
  task automatic settle();
    repeat (4) @(posedge ref_clk);
    #2;
  endtask : settle
  task automatic check_defaults();
    check(16'(drives), 16'(DRV_RST), "drives");
    check(16'(pols), 16'h0000, "polarities");
    check(16'(seq1_low), 16'h0040, "seq1 first");
    check(16'(seq1_second), 16'h0040, "seq1 second");
    check(16'(seq2_first), 16'h0040, "seq2 first");
    check(16'(seq2_second), 16'h0040, "seq2 second");
    check(16'(bank_select), 16'h0000, "bank");
    edge_at(3, 1'b1, 6'h00, "odd rise");
    edge_at(3, 1'b0, 6'h20, "odd fall");
    edge_at(2, 1'b1, 6'h20, "even rise");
    edge_at(4, 1'b1, 6'h00, "last rise");
    edge_at(4, 1'b0, 6'h18, "last fall");
    edge_at(5, 1'b1, 6'h00, "gate rise");
    edge_at(5, 1'b0, 6'h18, "gate fall");
    edge_at(1, 1'b1, 6'h20, "ref sample");
    edge_at(0, 1'b1, 6'h00, "data sample");
  endtask : check_defaults
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      $display("BAD t=%0t run did not finish", $time);
      finish_test();
    end
  end
  initial begin
    repeat (2) @(posedge ref_clk);
    #1;
    resetn = 1'b1;
    check_defaults();
    $display("Test defaults done");
    // Test nibble of address 8 set on purpose; it must be dropped
    host.write_burst(1'b0, '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hA5, 8'hF3,
      8'h5C, 8'h0A, 8'h11, 8'h0F, 8'hFF});
    settle();
    check(16'(seq1_low), 16'h00A5, "seq1 first");
    check(16'(seq1_second), 16'h035C, "seq1 second");
    check(16'(seq2_first), 16'h0A11, "seq2 first");
    check(16'(seq2_second), 16'h0FFF, "seq2 second");
    check(16'(drives), 16'(DRV_RST), "drives kept");
    $display("Test first bank done");
    // Last word lies beyond address 26 and is ignored
    host.write_burst(1'b1, '{8'h8D, 8'h05, 8'h2B, 8'h1A, 8'h33, 8'hF0, 8'hFB, 8'h00,
      8'h14, 8'h27, 8'h00, 8'h00, 8'h00, 8'hFF});
    settle();
    check(16'(drives), 16'({3'h5, 3'h0, 4'hF, 4'h0}), "drives");
    check(16'(pols), 16'h0007, "polarities");
    check(16'(bank_select), 16'h0001, "bank");
    check(16'(seq1_low), 16'h00A5, "seq1 kept");
    edge_at(5, 1'b0, 6'h1A, "gate inv rise");
    edge_at(5, 1'b1, 6'h33, "gate inv fall");
    edge_at(4, 1'b0, 6'h05, "last inv rise");
    edge_at(4, 1'b1, 6'h2B, "last inv fall");
    edge_at(3, 1'b0, 6'h3B, "odd inv rise");
    edge_at(3, 1'b1, 6'h00, "odd inv fall");
    edge_at(1, 1'b1, 6'h14, "ref sample");
    edge_at(0, 1'b1, 6'h27, "data sample");
    $display("Test second bank done");
    host.write_burst(1'b1, '{8'h00});
    settle();
    check(16'(drives), 16'({3'h0, 3'h0, 4'hF, 4'h0}), "drives off");
    check(16'(pols), 16'h0001, "polarities");
    $display("Test partial burst done");
    @(posedge ref_clk);
    #1;
    resetn = 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
    resetn = 1'b1;
    check_defaults();
    $display("Test second reset done");
    finish_test();
  end
endmodule : ccd_timing_register_bank_tb
